// File: hdl/pmt_defines.svh
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH
// Register byte offsets on the bus
`define PMT_OFF_COUNT 12'h000
`define PMT_OFF_CTRL 12'h004
`define PMT_OFF_PERIOD 12'h008
`define PMT_OFF_STATUS 12'h00C
`define PMT_OFF_MASK 12'h010
// Reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_CTRL 8'h00
`define PMT_RST_PERIOD 8'hFF
// Control field positions
`define PMT_CTRL_PRE_LO 0
`define PMT_CTRL_PRE_HI 1
`define PMT_CTRL_RUN 2
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_POST_HI 6
`define PMT_CTRL_WMASK 8'h7F
// Instruction clock divider: system clock / 4
`define PMT_ICLK_DIV 2'h3
// Prescale terminal counts
`define PMT_PRE_TC1 4'h0
`define PMT_PRE_TC4 4'h3
`define PMT_PRE_TC16 4'hF
`endif

// File: hdl/pmt_pkg.sv
package pmt_pkg;
	// AHB-Lite address phase captured for the data phase
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
	} pmt_req_t;
	// Time-base signals offered to the PWM unit
	typedef struct packed {
		logic [7:0] count;
		logic match;
	} pmt_base_t;
	// Bus slave phases
	typedef enum logic [0:0] {
		PMT_IDLE = 1'b0,
		PMT_DATA = 1'b1
	} pmt_phase_t;
endpackage

// File: hdl/pmt_prescaler.sv
`timescale 1ns/10ps
`include "pmt_defines.svh"
// Divides instruction-clock ticks by 1, 4 or 16; holds while stopped
module pmt_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic tickIn,
	input wire logic [1:0] sel,
	output logic tickOut
);
	logic [3:0] cnt_r;
	logic [3:0] tc;
	// (R3) select terminal count
	always_comb begin
		case (sel)
			2'b00: tc = `PMT_PRE_TC1;
			2'b01: tc = `PMT_PRE_TC4;
			default: tc = `PMT_PRE_TC16;
		endcase
	end
	assign tickOut = tickIn && (cnt_r >= tc);
	// (R6) cleared on write or reset
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			cnt_r <= 4'h0;
		end else if (tickIn) begin
			cnt_r <= (cnt_r >= tc) ? 4'h0 : cnt_r + 4'h1;
		end
	end
endmodule // pmt_prescaler

// File: hdl/pmt_postscaler.sv
`timescale 1ns/10ps
`include "pmt_defines.svh"
// Counts period matches, one event per (select + 1) matches
module pmt_postscaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic matchIn,
	input wire logic [3:0] sel,
	output logic eventOut
);
	logic [3:0] cnt_r;
	// (R4) divide by select plus one
	assign eventOut = matchIn && (cnt_r >= sel);
	// (R6) cleared on write or reset
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			cnt_r <= 4'h0;
		end else if (matchIn) begin
			cnt_r <= (cnt_r >= sel) ? 4'h0 : cnt_r + 4'h1;
		end
	end
endmodule // pmt_postscaler

// File: hdl/period_match_timer8.sv
// How it works
// (R1) Count from zero; at period match next increment returns to zero.
// (R2) Period resets to all ones; software reads and writes it anytime.
// (R3) Prescale 00 divides by 1, 01 by 4, 1x by 16.
// (R4) Postscaler divides period matches by field value plus one.
// (R5) Each postscaler event sets sticky interrupt flag until software clears.
// (R6) Count or control write, or reset, clears prescaler and postscaler.
// (R7) Control write leaves the count value unchanged.
// (R8) Count is software read/write and zero after reset.
// (R9) Run bit 2 starts or stops timer; off after reset.
// (R10) Raw match pulse before postscaler goes to serial port.
// (R11) Count and match offered to PWM unit as time base.
// (R12) Control bit 7 reads zero and ignores writes.
// (R13) While stopped, all counters hold and later resume. The instruction-clock divider keeps running.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "pmt_defines.svh"
module period_match_timer8 (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	output logic serialShiftTick,
	output pmt_pkg::pmt_base_t pwmBase
);
	import pmt_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [7:0] count_r;
	logic [7:0] ctrl_r;
	logic [7:0] period_r;
	logic status_r;
	logic mask_r;
	logic [1:0] iclk_r;
	pmt_req_t req_r;
	pmt_phase_t phase_r;
	logic [31:0] hrdata_r;
	logic irq_r;
	logic shift_r;
	pmt_base_t base_r;
	logic iclkTick;
	logic runTick;
	logic preTick;
	logic matchNow;
	logic incTick;
	logic postEvent;
	logic wrCount;
	logic wrCtrl;
	logic wrPeriod;
	logic wrMask;
	logic rdStatus;
	logic scalerClear;
	logic [31:0] rdMux;
	logic inData;
	logic statusNow;
	logic [7:0] fwdCount;
	logic [7:0] fwdCtrl;
	logic [7:0] fwdPeriod;
	logic fwdMask;
	logic [4:0] postSeen_r;
	logic [4:0] postLimit;
	logic [1:0] preSel;

	// Address decode shared by read and write paths
	function automatic logic hit(input pmt_req_t r, input logic [11:0] a);
		return r.addr == a;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Zero-wait slave: data phase completes in one cycle, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign irq = irq_r;
	assign serialShiftTick = shift_r;
	assign pwmBase = base_r;

	// Capture the address phase when the bus is ready
	always_ff @(posedge clk) begin
		if (rst) begin
			req_r <= '0;
			phase_r <= PMT_IDLE;
		end else if (hready) begin
			req_r.wr <= hsel && htrans[1] && hwrite;
			req_r.rd <= hsel && htrans[1] && !hwrite;
			req_r.addr <= haddr[11:0];
			phase_r <= (hsel && htrans[1]) ? PMT_DATA : PMT_IDLE;
		end
	end

	// Only a live data phase may act on the captured request
	assign inData = (phase_r == PMT_DATA);
	assign wrCount = inData && req_r.wr && hit(req_r, `PMT_OFF_COUNT);
	assign wrCtrl = inData && req_r.wr && hit(req_r, `PMT_OFF_CTRL);
	assign wrPeriod = inData && req_r.wr && hit(req_r, `PMT_OFF_PERIOD);
	assign wrMask = inData && req_r.wr && hit(req_r, `PMT_OFF_MASK);
	assign rdStatus = inData && req_r.rd && hit(req_r, `PMT_OFF_STATUS);

	// Forward a write still in its data phase, so a read pipelined
	// right behind it returns the new value and not a stale one
	assign fwdCount = wrCount ? hwdata[7:0] : count_r;
	assign fwdCtrl = wrCtrl ? hwdata[7:0] : ctrl_r;
	assign fwdPeriod = wrPeriod ? hwdata[7:0] : period_r;
	assign fwdMask = wrMask ? hwdata[0] : mask_r;

	// Flag as it stands after this edge; a landing event beats the clear
	assign statusNow = (status_r && !rdStatus) || postEvent;

	// Read mux on the live address phase; unmapped addresses read zero.
	// Decoding the address phase lets the data flop load at the edge
	// that ends it, so read data comes straight from a flip-flop.
	always_comb begin
		rdMux = 32'h0000_0000;
		case (haddr[11:0])
			`PMT_OFF_COUNT: rdMux[7:0] = fwdCount;
			// (R12) bit 7 reads zero
			`PMT_OFF_CTRL: rdMux[7:0] = fwdCtrl & `PMT_CTRL_WMASK;
			`PMT_OFF_PERIOD: rdMux[7:0] = fwdPeriod;
			`PMT_OFF_STATUS: rdMux[0] = statusNow;
			`PMT_OFF_MASK: rdMux[0] = fwdMask;
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// Read data loads as the address phase ends and stands for the
	// whole data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_r <= rdMux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Instruction clock: one tick every fourth system clock
	always_ff @(posedge clk) begin
		if (rst) begin
			iclk_r <= 2'h0;
		end else begin
			iclk_r <= iclk_r + 2'h1;
		end
	end
	assign iclkTick = (iclk_r == `PMT_ICLK_DIV);

	// (R9) gate ticks by the run bit
	// (R13) stopped means no tick, so count and both scalers hold
	assign runTick = iclkTick && ctrl_r[`PMT_CTRL_RUN];

	// (R6) any count or control write clears the scalers
	assign scalerClear = wrCount || wrCtrl;

	pmt_prescaler u_pre (
		.clk(clk),
		.rst(rst),
		.clear(scalerClear),
		.tickIn(runTick),
		.sel(ctrl_r[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO]),
		.tickOut(preTick)
	);

	// Match seen on an increment while count equals period
	assign matchNow = (count_r == period_r);
	assign incTick = preTick && !scalerClear;

	pmt_postscaler u_post (
		.clk(clk),
		.rst(rst),
		.clear(scalerClear),
		.matchIn(incTick && matchNow),
		.sel(ctrl_r[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO]),
		.eventOut(postEvent)
	);

	////////////////////////////////////////////////////////////////////
	// (R8) count: software write wins over increment
	always_ff @(posedge clk) begin
		if (rst) begin
			count_r <= `PMT_RST_COUNT;
		end else if (wrCount) begin
			count_r <= hwdata[7:0];
		// (R1) wrap to zero on match
		end else if (incTick) begin
			count_r <= matchNow ? `PMT_RST_COUNT : count_r + 8'h01;
		end
	end

	// (R7) control write touches only control bits
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `PMT_RST_CTRL;
		end else if (wrCtrl) begin
			// (R12) bit 7 write ignored
			ctrl_r <= hwdata[7:0] & `PMT_CTRL_WMASK;
		end
	end

	// (R2) period register, all ones after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			period_r <= `PMT_RST_PERIOD;
		end else if (wrPeriod) begin
			period_r <= hwdata[7:0];
		end
	end

	// (R5) sticky flag; a set beats the clear-on-read
	always_ff @(posedge clk) begin
		if (rst) begin
			status_r <= 1'b0;
		end else if (postEvent) begin
			status_r <= 1'b1;
		end else if (rdStatus) begin
			status_r <= 1'b0;
		end
	end

	// Interrupt mask, one bit matching the status layout
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_r <= 1'b0;
		end else if (wrMask) begin
			mask_r <= hwdata[0];
		end
	end

	// Registered outputs; one cycle behind the internal event
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= 1'b0;
			shift_r <= 1'b0;
			base_r <= '0;
		end else begin
			// Drops with the clear-on-read, rises with the event
			irq_r <= statusNow && mask_r;
			// (R10) raw match to serial port
			shift_r <= incTick && matchNow;
			// (R11) time base to PWM unit
			base_r.count <= count_r;
			base_r.match <= incTick && matchNow;
		end
	end

	////////////////////////////////////////////////////////////////////
	// (R4) reference count of raw matches since the last event or clear
	always_ff @(posedge clk) begin
		if (rst || scalerClear || postEvent) begin
			postSeen_r <= 5'h00;
		end else if (incTick && matchNow) begin
			postSeen_r <= postSeen_r + 5'h01;
		end
	end
	assign postLimit = {1'b0, ctrl_r[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO]};
	assign preSel = ctrl_r[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO];

	////////////////////////////////////////////////////////////////////
	// (R1) wrap after match
	AST_WRAP: assert property (@(posedge clk) disable iff (rst) // R1
		incTick && matchNow && !wrCount |=> count_r == 8'h00)
		else $error("count did not wrap at period");
	// (R2) period reset value
	AST_PERIOD_RST: assert property (@(posedge clk) // R2
		$fell(rst) |-> period_r == 8'hFF)
		else $error("period not all ones after reset");
	// (R3) divide by 16 spacing
	AST_PRE16: assert property (@(posedge clk) disable iff (rst) // R3
		preTick && ctrl_r[1] && !scalerClear |=> !preTick [*8])
		else $error("prescale 16 ticked too soon");
	// (R5) flag set by event
	AST_FLAG: assert property (@(posedge clk) disable iff (rst) // R5
		postEvent |=> status_r)
		else $error("flag not set by event");
	// (R6) count write clears scalers
	AST_CLR: assert property (@(posedge clk) disable iff (rst) // R6
		wrCount |=> u_pre.cnt_r == 4'h0 && u_post.cnt_r == 4'h0)
		else $error("scalers not cleared");
	// (R7) control write keeps count
	AST_KEEP: assert property (@(posedge clk) disable iff (rst) // R7
		wrCtrl && !wrCount |=> $stable(count_r))
		else $error("control write changed count");
	// (R9) stopped timer holds count
	AST_STOP: assert property (@(posedge clk) disable iff (rst) // R9
		!ctrl_r[2] && !wrCount |=> $stable(count_r))
		else $error("count moved while off");
	// (R12) bit 7 never set
	AST_BIT7: assert property (@(posedge clk) disable iff (rst) // R12
		!ctrl_r[7])
		else $error("control bit 7 set");
	// (R10) serial tick follows match
	AST_SHIFT: assert property (@(posedge clk) disable iff (rst) // R10
		incTick && matchNow |=> serialShiftTick && pwmBase.match)
		else $error("match not forwarded");

	// (R6) control write clears scalers
	AST_CTRL_CLR: assert property (@(posedge clk) disable iff (rst) // R6
		wrCtrl |=> u_pre.cnt_r == 4'h0 && u_post.cnt_r == 4'h0)
		else $error("scalers not cleared by control write");
	// (R8) count write lands
	AST_COUNT_WR: assert property (@(posedge clk) disable iff (rst) // R8
		wrCount |=> count_r == $past(hwdata[7:0]))
		else $error("count write lost");
	// (R2) period write lands
	AST_PERIOD_WR: assert property (@(posedge clk) disable iff (rst) // R2
		wrPeriod |=> period_r == $past(hwdata[7:0]))
		else $error("period write lost");
	// (R5) flag latched until read
	AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst) // R5
		status_r && !rdStatus |=> status_r)
		else $error("flag dropped without a read");
	// (R5) unmasked flag drives the line
	AST_IRQ_HIGH: assert property (@(posedge clk) disable iff (rst) // R5
		status_r && mask_r && !rdStatus |=> irq)
		else $error("interrupt low with unmasked flag");
	// (R5) no flag, no line
	AST_IRQ_LOW: assert property (@(posedge clk) disable iff (rst) // R5
		!status_r && !postEvent |=> !irq)
		else $error("interrupt high with no flag");
	// (R11) PWM count copy one cycle behind
	AST_BASE: assert property (@(posedge clk) disable iff (rst) // R11
		1'b1 |=> pwmBase.count == $past(count_r))
		else $error("PWM count copy wrong");
	// (R13) stopped scalers hold their counts
	AST_HOLD_SCALE: assert property (@(posedge clk) disable iff (rst) // R13
		!ctrl_r[`PMT_CTRL_RUN] && !scalerClear |=>
		$stable(u_pre.cnt_r) && $stable(u_post.cnt_r))
		else $error("scaler moved while stopped");
	// (R4) event on every select-plus-one match
	AST_POST_N: assert property (@(posedge clk) disable iff (rst) // R4
		incTick && matchNow |-> postEvent == (postSeen_r == postLimit))
		else $error("postscale event on wrong match");
	// (R3) divide by 4 spacing
	AST_PRE4: assert property (@(posedge clk) disable iff (rst) // R3
		preTick && preSel == 2'b01 && !scalerClear |=> !preTick [*8])
		else $error("prescale 4 ticked too soon");
	// (R3) divide by 1 passes every tick
	AST_PRE1: assert property (@(posedge clk) disable iff (rst) // R3
		preSel == 2'b00 |-> preTick == runTick)
		else $error("prescale 1 dropped a tick");

	COV_WRAP: cover property (@(posedge clk) incTick && matchNow);
	COV_EVENT: cover property (@(posedge clk) postEvent);
	COV_IRQ: cover property (@(posedge clk) irq_r);
	COV_CLEAR: cover property (@(posedge clk) wrCtrl && ctrl_r[2]);
	COV_STATUS_READ: cover property (@(posedge clk) rdStatus && status_r);
endmodule // period_match_timer8

// File: sim/pmt_far_model.sv
`timescale 1ns/10ps
// Far side: serial port and PWM unit counting raw match pulses
module pmt_far_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic serialShiftTick,
	input wire pmt_pkg::pmt_base_t pwmBase,
	output int matchCount,
	output int pwmCount,
	output int lastGap
);
	import pmt_pkg::*;
	int gapCnt;
	// A shift-clock user relies on an even gap between ticks
	always_ff @(posedge clk) begin
		if (rst) begin
			matchCount <= 0;
			pwmCount <= 0;
			gapCnt <= 0;
			lastGap <= 0;
		end else begin
			gapCnt <= serialShiftTick ? 1 : gapCnt + 1;
			pwmCount <= pwmCount + int'(pwmBase.match);
			if (serialShiftTick) begin
				matchCount <= matchCount + 1;
				lastGap <= gapCnt;
			end
		end
	end
endmodule // pmt_far_model

// File: sim/period_match_timer8_tb.sv
`timescale 1ns/10ps
`include "pmt_defines.svh"
module period_match_timer8_tb;
	import pmt_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = ZERO, hwdata = ZERO, hrdata, rd;
	logic hready, hreadyout, hresp, irq, serialShiftTick;
	pmt_base_t pwmBase;
	int matchCount, pwmCount, lastGap, errCount = 0, checkCount = 0;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	period_match_timer8 dut (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.serialShiftTick(serialShiftTick), .pwmBase(pwmBase));
	pmt_far_model far (.clk(clk), .rst(rst),
		.serialShiftTick(serialShiftTick), .pwmBase(pwmBase),
		.matchCount(matchCount), .pwmCount(pwmCount), .lastGap(lastGap));
	// Free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] want);
		checkCount++;
		if (seen !== want) begin
			errCount++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic bit hit(int what, int target);
		case (what)
			0: return matchCount >= target;
			1: return irq === 1'b1;
			default: return hready === 1'b1;
		endcase
	endfunction
	// Bounded wait: 0 match count, 1 interrupt, 2 bus ready
	task wait_for(input int what, input int target);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!hit(what, target) && n < 3000);
		if (!hit(what, target)) begin
			errCount++;
			$display("unexpected at %0t: wait ran out", $time);
			give_verdict;
		end
	endtask
	// One word transfer; read data is taken at the closing edge
	task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0_0000, a};
		hwrite <= wr;
		wait_for(2, 0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		wait_for(2, 0);
		rd = hrdata;
	endtask
	////////////////////////////////////////////////////////////////////
	task t_reset;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 12'(i * 4), 8'h00);
			check(rd, i == 2 ? 32'h0000_00ff : ZERO); // Reset values
		end
		bus(1'b1, 12'h014, 8'hff);
		bus(1'b0, 12'h014, 8'h00);
		check(rd, ZERO); // Unmapped write dropped
		check(irq, ZERO); // Quiet after reset
		check(hresp, ZERO); // Response always OKAY
		$display("reset test done");
	endtask
	task t_ctrl;
		bus(1'b1, `PMT_OFF_CTRL, 8'hff);
		bus(1'b0, `PMT_OFF_CTRL, 8'h00);
		check(rd, 32'h0000_007f); // Top bit reads zero
		bus(1'b1, `PMT_OFF_CTRL, 8'h00);
		$display("control test done");
	endtask
	// Every prescale code, short period so all gaps stay small
	task t_wrap;
		int div;
		bus(1'b1, `PMT_OFF_PERIOD, 8'h03);
		for (int c = 0; c < 4; c++) begin
			div = c == 0 ? 1 : c == 1 ? 4 : 16;
			bus(1'b1, `PMT_OFF_CTRL, 8'(4 + c));
			wait_for(0, matchCount + 3);
			check(lastGap, 16 * div); // Wrap and prescale
		end
		bus(1'b1, `PMT_OFF_CTRL, 8'h00);
		repeat (4) @(posedge clk);
		check(pwmCount, matchCount); // PWM sees each match
		bus(1'b0, `PMT_OFF_COUNT, 8'h00);
		check(rd <= 32'h0000_0003, ONE); // Count never passes period
		$display("wrap test done");
	endtask
	task t_post;
		int m;
		logic [3:0] p;
		bus(1'b1, `PMT_OFF_PERIOD, 8'h01);
		bus(1'b1, `PMT_OFF_MASK, 8'h01);
		for (int k = 0; k < 3; k++) begin
			p = k == 0 ? 4'h0 : k == 1 ? 4'h2 : 4'hf;
			bus(1'b0, `PMT_OFF_STATUS, 8'h00);
			bus(1'b1, `PMT_OFF_CTRL, {1'b0, p, 3'h4});
			m = matchCount;
			wait_for(1, 0);
			// The model counts the last match one edge after the flag
			bus(1'b1, `PMT_OFF_CTRL, 8'h00);
			check(matchCount - m, p + 1); // Postscale count
			check(irq, ONE); // Flag stays latched
			bus(1'b0, `PMT_OFF_STATUS, 8'h00);
			check(rd, ONE); // Flag reads set
			@(posedge clk);
			@(posedge clk);
			check(irq, ZERO); // Read clears flag
		end
		// Masked event must still set the flag but not the line
		bus(1'b1, `PMT_OFF_MASK, 8'h00);
		bus(1'b1, `PMT_OFF_CTRL, 8'h04);
		wait_for(0, matchCount + 2);
		bus(1'b1, `PMT_OFF_CTRL, 8'h00);
		check(irq, ZERO); // Masked line low
		bus(1'b0, `PMT_OFF_STATUS, 8'h00);
		check(rd, ONE); // Masked flag set
		$display("postscale test done");
	endtask
	task t_hold;
		logic [31:0] c;
		bus(1'b1, `PMT_OFF_PERIOD, 8'hff);
		bus(1'b1, `PMT_OFF_COUNT, 8'h10);
		bus(1'b1, `PMT_OFF_CTRL, 8'h04);
		repeat (40) @(posedge clk);
		bus(1'b1, `PMT_OFF_CTRL, 8'h00);
		bus(1'b0, `PMT_OFF_COUNT, 8'h00);
		c = rd;
		check(c > 32'h0000_0010, ONE); // Counts on from written value
		check(pwmBase.count, c); // PWM count copy
		repeat (40) @(posedge clk);
		bus(1'b1, `PMT_OFF_CTRL, 8'h02);
		bus(1'b0, `PMT_OFF_COUNT, 8'h00);
		check(rd, c); // Held while off, kept on write
		bus(1'b1, `PMT_OFF_COUNT, 8'h20);
		bus(1'b0, `PMT_OFF_COUNT, 8'h00);
		check(rd, 32'h0000_0020); // Count write
		$display("hold test done");
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence: reset for 16 cycles, then each scenario
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_ctrl;
		t_wrap;
		t_post;
		t_hold;
		give_verdict;
	end
endmodule // period_match_timer8_tb
